// ==== design/csb_exec.sv ====
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "csb_map.svh"
module csb_exec (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // APB slave
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Instruction issue from fetch
  input  wire logic                 op_valid,
  output logic                      op_ready,
  input  wire csb_pkg::csb_op_type  op_code,
  input  wire csb_pkg::csb_src_type op_src,
  input  wire logic [2:0]           op_bit,
  input  wire logic [19:0]          op_imm,
  input  wire logic [7:0]           op_disp,
  input  wire logic [19:0]          op_pc,
  input  wire logic                 op_flash,
  input  wire logic [1:0]           op_bank,
  // Core registers from the register file
  input  wire logic [15:0]          accumulator_pair,
  input  wire logic [15:0]          register_pair,
  input  wire logic [15:0]          memory_pointer_pair,
  input  wire logic [3:0]           extra_segment_register,
  input  wire logic [3:0]           code_segment,
  // Results
  output logic                      done,
  output logic      [19:0]          pc_next,
  output logic                      skip_next,
  output logic                      acc_wr,
  output logic      [7:0]           acc_wdata,
  output logic                      pair_wr,
  output logic      [15:0]          pair_wdata,
  output logic      [7:0]           program_status_word,
  output logic      [15:0]          stack_pointer,
  // Standby
  input  wire logic                 wake,
  output logic                      halt_mode,
  output logic                      stop_mode,
  // Data memory
  output logic                      mem_req,
  output logic                      mem_we,
  output logic                      mem_wide,
  output logic      [19:0]          mem_addr,
  output logic      [15:0]          mem_wdata,
  input  wire logic [15:0]          mem_rdata
);
  import csb_pkg::*;

  csb_state_type state_r;
  csb_state_type state_nxt;
  csb_op_type    code_r;
  csb_src_type   src_r;
  logic [2:0]    bit_r;
  logic [19:0]   imm_r;
  logic [19:0]   pc_r;
  logic [7:0]    disp_r;
  logic          flash_r;
  logic [1:0]    bank_r;
  logic [15:0]   pair_r;
  logic [3:0]    cnt_r;
  logic [3:0]    cnt_nxt;
  logic [7:0]    status_r;
  logic [7:0]    status_nxt;
  logic [15:0]   stack_r;
  logic [15:0]   stack_nxt;
  logic          cond_true;
  logic          wr_status;
  logic          wr_stack;

  function automatic logic [3:0] clocks(input csb_op_type c, input csb_src_type s,
                                        input logic fl, input logic t);
    logic slow;
    slow = fl & (c != OP_TEST_CLEAR);
    case (c)
      OP_POP_STATUS: clocks = `CSB_CYC_POP_STATUS;
      OP_BR_ACC, OP_BR_SHORT, OP_BR_LONG, OP_BR_ABS: clocks = `CSB_CYC_JUMP;
      OP_BR_CARRY, OP_BR_NO_CARRY, OP_BR_ZERO, OP_BR_NO_ZERO,
      OP_HIGHER, OP_NOT_HIGHER: clocks = t ? `CSB_CYC_FLAG_T : `CSB_CYC_FLAG_NT;
      OP_BIT_TRUE, OP_BIT_FALSE, OP_TEST_CLEAR: begin
        if (s == SRC_SEG_PTR && slow) begin
          clocks = t ? `CSB_CYC_SEGF_T : `CSB_CYC_SEGF_NT;
        end else if (s == SRC_SEG_PTR) begin
          clocks = t ? `CSB_CYC_SEG_T : `CSB_CYC_SEG_NT;
        end else if (s == SRC_PTR && slow) begin
          clocks = t ? `CSB_CYC_PTRF_T : `CSB_CYC_PTRF_NT;
        end else begin
          clocks = t ? `CSB_CYC_BIT_T : `CSB_CYC_BIT_NT;
        end
      end
      OP_INT_ENABLE, OP_INT_DISABLE: clocks = `CSB_CYC_INT;
      OP_HALT, OP_STOP: clocks = `CSB_CYC_STANDBY;
      default: clocks = `CSB_CYC_ONE;
    endcase
  endfunction

  function automatic logic [2:0] op_len(input csb_op_type c, input csb_src_type s);
    case (c)
      OP_PUSH_PAIR, OP_POP_PAIR, OP_NOP: op_len = `CSB_LEN_1;
      OP_BR_LONG, OP_HIGHER, OP_NOT_HIGHER: op_len = `CSB_LEN_3;
      OP_INT_ENABLE, OP_INT_DISABLE: op_len = `CSB_LEN_3;
      OP_BIT_TRUE, OP_BIT_FALSE, OP_TEST_CLEAR:
        op_len = (s == SRC_ACC || s == SRC_PTR) ? `CSB_LEN_3 : `CSB_LEN_4;
      default: op_len = `CSB_LEN_2;
    endcase
  endfunction

  // Decode of the latched operation.
  wire logic accept   = op_valid & op_ready;
  wire logic in_exec  = (state_r == ST_EXEC);
  wire logic in_wait  = (state_r == ST_WAIT);
  wire logic is_bit   = (code_r == OP_BIT_TRUE) | (code_r == OP_BIT_FALSE) | (code_r == OP_TEST_CLEAR);
  wire logic is_flag  = (code_r >= OP_BR_CARRY) & (code_r <= OP_NOT_HIGHER);
  wire logic is_skip  = (code_r >= OP_SKIP_CARRY) & (code_r <= OP_NOT_HIGHER_SKIP);
  wire logic push_st  = in_exec & (code_r == OP_PUSH_STATUS);
  wire logic push_pr  = in_exec & (code_r == OP_PUSH_PAIR);
  wire logic pop_st   = in_exec & (code_r == OP_POP_STATUS);
  wire logic pop_pr   = in_exec & (code_r == OP_POP_PAIR);
  wire logic mem_src  = (src_r != SRC_ACC) & (src_r != SRC_STATUS);
  wire logic do_clear = in_exec & (code_r == OP_TEST_CLEAR) & cond_true;

  // Stack addresses.
  wire logic [15:0] stack_m2 = stack_r - 16'h0002;
  wire logic [15:0] stack_p1 = stack_r + 16'h0001;
  wire logic [15:0] stack_p2 = stack_r + 16'h0002;

  // Bit operand selection.
  wire logic [19:0] opnd_addr = (src_r == SRC_SEG_PTR) ? {extra_segment_register, memory_pointer_pair} :
                                (src_r == SRC_PTR) ? {`CSB_RAM_BANK, memory_pointer_pair} : imm_r;
  wire logic [7:0]  bit_mask  = 8'h01 << bit_r;
  wire logic [7:0]  opnd_byte = (src_r == SRC_ACC) ? accumulator_pair[15:8] :
                                (src_r == SRC_STATUS) ? status_r : mem_rdata[7:0];
  wire logic        bit_val   = |(opnd_byte & bit_mask);
  wire logic [7:0]  cleared   = opnd_byte & ~bit_mask;

  // Clock count and program counter targets.
  wire logic [3:0]  cyc       = clocks(code_r, src_r, flash_r, cond_true);
  wire logic [19:0] next_seq  = pc_r + {17'h00000, op_len(code_r, src_r)};
  wire logic [19:0] tgt_short = next_seq + {{12{disp_r[7]}}, disp_r};
  wire logic [19:0] tgt_long  = next_seq + {{4{imm_r[15]}}, imm_r[15:0]};
  wire logic [19:0] pc_calc   = (code_r == OP_BR_ACC) ? {code_segment, accumulator_pair} :
                                (code_r == OP_BR_ABS) ? imm_r :
                                (code_r == OP_BR_LONG) ? tgt_long :
                                ((code_r == OP_BR_SHORT) | ((is_flag | is_bit) & cond_true)) ? tgt_short :
                                next_seq;
  wire logic        last      = (in_exec & (cyc == `CSB_CYC_ONE)) | (in_wait & (cnt_r == `CSB_CYC_ONE));

  csb_cond u_cond (
    .code    (code_r),
    .zero    (status_r[`CSB_FLAG_ZERO]),
    .carry   (status_r[`CSB_FLAG_CARRY]),
    .bit_val (bit_val),
    .taken   (cond_true)
  );

  csb_apb u_apb (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .paddr     (paddr),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .status_in (status_r),
    .stack_in  (stack_r),
    .state_in  ({stop_mode, halt_mode, skip_next, ~op_ready}),
    .pc_in     (pc_next),
    .wr_status (wr_status),
    .wr_stack  (wr_stack)
  );

  // Memory port, driven only in the execute cycle.
  assign mem_req   = push_st | push_pr | pop_st | pop_pr | (in_exec & is_bit & mem_src);
  assign mem_we    = push_st | push_pr | (do_clear & mem_src);
  assign mem_wide  = push_st | push_pr | pop_pr;
  assign mem_addr  = (push_st | push_pr) ? {`CSB_RAM_BANK, stack_m2} :
                     pop_pr ? {`CSB_RAM_BANK, stack_r} :
                     pop_st ? {`CSB_RAM_BANK, stack_p1} : opnd_addr;
  assign mem_wdata = push_st ? {status_r, 8'h00} :
                     push_pr ? pair_r : {8'h00, cleared};

  assign op_ready  = (state_r == ST_IDLE) & ~halt_mode & ~stop_mode;
  assign state_nxt = accept ? ST_EXEC : last ? ST_IDLE : in_exec ? ST_WAIT : state_r;
  assign cnt_nxt   = in_exec ? cyc - `CSB_CYC_ONE : in_wait ? cnt_r - `CSB_CYC_ONE : cnt_r;
  assign stack_nxt = wr_stack ? pwdata[15:0] :
                     (push_st | push_pr) ? stack_m2 :
                     (pop_st | pop_pr) ? stack_p2 : stack_r;

  // Status word updates; a bus write overrides the execute cycle.
  always_comb begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = pwdata[7:0];
    end else if (pop_st) begin
      status_nxt = mem_rdata[7:0];
    end else if (do_clear & (src_r == SRC_STATUS)) begin
      status_nxt = cleared;
    end else if (in_exec & (code_r == OP_INT_DISABLE)) begin
      status_nxt[`CSB_FLAG_INTEN] = 1'b0;
    end else if (in_exec & (code_r == OP_INT_ENABLE)) begin
      status_nxt[`CSB_FLAG_INTEN] = 1'b1;
    end else if (in_exec & (code_r == OP_BANK_SELECT)) begin
      status_nxt[`CSB_BANK_HI] = bank_r[1];
      status_nxt[`CSB_BANK_LO] = bank_r[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 4'h0;
      status_r <= `CSB_RST_STATUS;
      stack_r  <= `CSB_RST_STACK;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      status_r <= status_nxt;
      stack_r  <= stack_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_r  <= OP_NOP;
      src_r   <= SRC_SHORT_DIRECT;
      bit_r   <= 3'h0;
      imm_r   <= 20'h00000;
      disp_r  <= 8'h00;
      pc_r    <= 20'h00000;
      flash_r <= 1'b0;
      bank_r  <= 2'h0;
      pair_r  <= 16'h0000;
    end else if (accept) begin
      code_r  <= op_code;
      src_r   <= op_src;
      bit_r   <= op_bit;
      imm_r   <= op_imm;
      disp_r  <= op_disp;
      pc_r    <= op_pc;
      flash_r <= op_flash;
      bank_r  <= op_bank;
      pair_r  <= register_pair;
    end
  end

  // Results; standby is set by its instruction and left on wake.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      done       <= 1'b0;
      pc_next    <= 20'h00000;
      skip_next  <= 1'b0;
      acc_wr     <= 1'b0;
      acc_wdata  <= 8'h00;
      pair_wr    <= 1'b0;
      pair_wdata <= 16'h0000;
      halt_mode  <= 1'b0;
      stop_mode  <= 1'b0;
    end else begin
      done       <= last;
      pc_next    <= in_exec ? pc_calc : pc_next;
      skip_next  <= (in_exec & is_skip) ? cond_true : (accept ? 1'b0 : skip_next);
      acc_wr     <= do_clear & (src_r == SRC_ACC);
      acc_wdata  <= (do_clear & (src_r == SRC_ACC)) ? cleared : acc_wdata;
      pair_wr    <= pop_pr;
      pair_wdata <= pop_pr ? mem_rdata : pair_wdata;
      halt_mode  <= (in_exec & (code_r == OP_HALT)) | (halt_mode & ~wake);
      stop_mode  <= (in_exec & (code_r == OP_STOP)) | (stop_mode & ~wake);
    end
  end

  assign program_status_word = status_r;
  assign stack_pointer       = stack_r;

  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  push_status_a:
    assert property (push_st && !wr_stack |-> mem_we && mem_addr == {`CSB_RAM_BANK, stack_m2}
                     && mem_wdata == {status_r, 8'h00} ##1 stack_r == $past(stack_r) - 16'h0002)
    else $error("status push wrong");
  push_pair_a:
    assert property (push_pr |-> mem_wide && mem_wdata == pair_r ##1 state_r == ST_IDLE)
    else $error("pair push wrong");
  pop_status_a:
    assert property (accept && op_code == OP_POP_STATUS |=> !op_ready [*3] ##1 op_ready)
    else $error("status pop timing wrong");
  pop_pair_a:
    assert property (pop_pr && !wr_stack |=> stack_r == $past(stack_r) + 16'h0002
                     && pair_wr && pair_wdata == $past(mem_rdata))
    else $error("pair pop wrong");
  jump_time_a:
    assert property (accept && op_code inside {OP_BR_ACC, OP_BR_SHORT, OP_BR_LONG, OP_BR_ABS}
                     |=> !op_ready [*3] ##1 op_ready)
    else $error("jump timing wrong");
  flag_taken_a:
    assert property (in_exec && is_flag && cond_true |=> pc_next == $past(tgt_short)
                     && !op_ready ##1 !op_ready [*2] ##1 op_ready)
    else $error("taken flag branch wrong");
  flag_skip_a:
    assert property (in_exec && is_flag && !cond_true |-> !op_ready
                     ##1 (!op_ready && pc_next == $past(next_seq)) ##1 op_ready)
    else $error("untaken flag branch wrong");
  higher_cond_a:
    assert property (in_exec && code_r == OP_HIGHER |-> cond_true == !(status_r[`CSB_FLAG_ZERO]
                     || status_r[`CSB_FLAG_CARRY]))
    else $error("higher condition wrong");
  bit_time_a:
    assert property (in_exec && is_bit && !flash_r && src_r != SRC_SEG_PTR && cond_true
                     |=> !op_ready [*4] ##1 op_ready)
    else $error("bit branch timing wrong");
  clear_bit_a:
    assert property (do_clear && mem_src |-> mem_we && mem_wdata[7:0] == (mem_rdata[7:0] & ~bit_mask))
    else $error("bit not cleared");
  acc_clear_a:
    assert property (do_clear && src_r == SRC_ACC |=> acc_wr
                     && acc_wdata == ($past(accumulator_pair[15:8]) & ~bit_mask))
    else $error("accumulator clear wrong");
  skip_flag_a:
    assert property (in_exec && is_skip |=> skip_next == $past(cond_true) && op_ready)
    else $error("skip wrong");
  int_off_a:
    assert property (in_exec && code_r == OP_INT_DISABLE && !wr_status
                     |=> !status_r[`CSB_FLAG_INTEN] && !op_ready ##1 !op_ready [*2] ##1 op_ready)
    else $error("interrupt disable wrong");
  bank_sel_a:
    assert property (in_exec && code_r == OP_BANK_SELECT && !wr_status
                     |=> {status_r[`CSB_BANK_HI], status_r[`CSB_BANK_LO]} == $past(bank_r) && op_ready)
    else $error("bank select wrong");

  taken_flag_c: cover property (in_exec && is_flag && cond_true);
  clear_mem_c:  cover property (do_clear && mem_src);
  pop_status_c: cover property (pop_st);
  halt_wake_c:  cover property (halt_mode ##1 !halt_mode);
endmodule
`default_nettype wire

// ==== pkg/csb_map.svh ====
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH
// Notes on behaviour
// - Status push: status, zero byte, pointer minus two.
// - Pair push: high then low byte, one clock.
// - Status pop from pointer plus one, three clocks.
// - Pair pop: low at pointer, high next, plus two.
// - Jumps take three clocks; long and accumulator forms.
// - Flag branches: short displacement, two or four clocks.
// - Higher branch taken when zero and carry both clear.
// - Not taken uses smaller count, taken larger.
// - Bit-true branch jumps on set bit, three/five clocks.
// - Bit-false branch jumps on clear bit, same timing.
// - Test-clear branch jumps and clears the set bit.
// - Segment operands, and flash operands except for test-clear, use longer clock counts.
// - Primary counts for RAM, special registers, no data.
// - Flag skips suppress next instruction, one clock.
// - Higher skip on zero-or-carry clear, complement on set.
// - Interrupt disable clears enable flag; both four clocks.

`define CSB_ADDR_STATUS     8'h00
`define CSB_ADDR_STACK      8'h04
`define CSB_ADDR_STATE      8'h08
`define CSB_ADDR_PC         8'h0C
`define CSB_RST_STATUS      8'h00
`define CSB_RST_STACK       16'h0000
`define CSB_RAM_BANK        4'hF
`define CSB_FLAG_INTEN      7
`define CSB_FLAG_ZERO       6
`define CSB_BANK_HI         5
`define CSB_FLAG_AUXC       4
`define CSB_BANK_LO         3
`define CSB_FLAG_CARRY      0
`define CSB_LEN_1           3'd1
`define CSB_LEN_2           3'd2
`define CSB_LEN_3           3'd3
`define CSB_LEN_4           3'd4
`define CSB_CYC_ONE         4'd1
`define CSB_CYC_POP_STATUS  4'd3
`define CSB_CYC_JUMP        4'd3
`define CSB_CYC_FLAG_NT     4'd2
`define CSB_CYC_FLAG_T      4'd4
`define CSB_CYC_BIT_NT      4'd3
`define CSB_CYC_BIT_T       4'd5
`define CSB_CYC_SEG_NT      4'd4
`define CSB_CYC_SEG_T       4'd6
`define CSB_CYC_PTRF_NT     4'd6
`define CSB_CYC_PTRF_T      4'd7
`define CSB_CYC_SEGF_NT     4'd7
`define CSB_CYC_SEGF_T      4'd8
`define CSB_CYC_INT         4'd4
`define CSB_CYC_STANDBY     4'd3
`endif

// ==== pkg/csb_pkg.sv ====
`default_nettype none
package csb_pkg;
  typedef enum logic [4:0] {
    OP_PUSH_STATUS, OP_PUSH_PAIR, OP_POP_STATUS, OP_POP_PAIR,
    OP_BR_ACC, OP_BR_SHORT, OP_BR_LONG, OP_BR_ABS,
    OP_BR_CARRY, OP_BR_NO_CARRY, OP_BR_ZERO, OP_BR_NO_ZERO,
    OP_HIGHER, OP_NOT_HIGHER, OP_BIT_TRUE, OP_BIT_FALSE, OP_TEST_CLEAR,
    OP_SKIP_CARRY, OP_SKIP_NO_CARRY, OP_SKIP_ZERO, OP_SKIP_NO_ZERO,
    OP_HIGHER_SKIP, OP_NOT_HIGHER_SKIP, OP_BANK_SELECT, OP_NOP,
    OP_INT_ENABLE, OP_INT_DISABLE, OP_HALT, OP_STOP
  } csb_op_type;
  typedef enum logic [2:0] {
    SRC_SHORT_DIRECT, SRC_SPECIAL, SRC_ACC, SRC_STATUS, SRC_PTR, SRC_SEG_PTR
  } csb_src_type;
  typedef enum {ST_IDLE, ST_EXEC, ST_WAIT} csb_state_type;
endpackage
`default_nettype wire

// ==== design/csb_cond.sv ====
`timescale 1ns/10ps
`default_nettype none
module csb_cond (
  // Operation and inputs to the test
  input  wire csb_pkg::csb_op_type code,
  input  wire logic                zero,
  input  wire logic                carry,
  input  wire logic                bit_val,
  // Condition met
  output logic                     taken
);
  import csb_pkg::*;

  wire logic higher = ~(zero | carry);

  always_comb begin
    case (code)
      OP_BR_ACC, OP_BR_SHORT, OP_BR_LONG, OP_BR_ABS: taken = 1'b1;
      OP_BR_CARRY, OP_SKIP_CARRY: taken = carry;
      OP_BR_NO_CARRY, OP_SKIP_NO_CARRY: taken = ~carry;
      OP_BR_ZERO, OP_SKIP_ZERO: taken = zero;
      OP_BR_NO_ZERO, OP_SKIP_NO_ZERO: taken = ~zero;
      OP_HIGHER, OP_HIGHER_SKIP: taken = higher;
      OP_NOT_HIGHER, OP_NOT_HIGHER_SKIP: taken = ~higher;
      OP_BIT_TRUE, OP_TEST_CLEAR: taken = bit_val;
      OP_BIT_FALSE: taken = ~bit_val;
      default: taken = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== design/csb_apb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "csb_map.svh"
module csb_apb (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Block state
  input  wire logic [7:0]  status_in,
  input  wire logic [15:0] stack_in,
  input  wire logic [3:0]  state_in,
  input  wire logic [19:0] pc_in,
  output logic             wr_status,
  output logic             wr_stack
);
  wire logic hit_status = (paddr == `CSB_ADDR_STATUS);
  wire logic hit_stack  = (paddr == `CSB_ADDR_STACK);
  wire logic hit_state  = (paddr == `CSB_ADDR_STATE);
  wire logic hit_pc     = (paddr == `CSB_ADDR_PC);
  wire logic mapped     = hit_status | hit_stack | hit_state | hit_pc;
  wire logic access     = psel & penable;
  wire logic [31:0] rd_mux = hit_status ? {24'h000000, status_in} :
                             hit_stack  ? {16'h0000, stack_in} :
                             hit_state  ? {28'h0000000, state_in} :
                             hit_pc     ? {12'h000, pc_in} : 32'h00000000;

  assign pready    = 1'b1;
  assign pslverr   = access & ~mapped;
  assign wr_status = access & pwrite & hit_status;
  assign wr_stack  = access & pwrite & hit_stack;

  // Read data is captured in the setup cycle so the bus sees a register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      prdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// ==== sim/csb_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module csb_mem_model (
  // Clock
  input  wire logic        mclk,
  // Data memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_wide,
  input  wire logic [19:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [7:0]  ram [0:1048575];
  logic [15:0] last_r = 16'h0000;
  // An idle port shows a changing pattern, never the last data.
  assign mem_rdata = mem_req ? {ram[20'(mem_addr + 20'h1)], ram[mem_addr]} : ~last_r;
  always @(posedge mclk) begin
    last_r <= mem_rdata;
    if (mem_req && mem_we) begin
      ram[mem_addr] <= mem_wdata[7:0];
      if (mem_wide) ram[20'(mem_addr + 20'h1)] <= mem_wdata[15:8];
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_cpu_stack_branch_control_ops.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_cpu_stack_branch_control_ops;
  import csb_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wake = 1'b0;
  logic        op_valid = 1'b0, op_flash = 1'b0, op_ready, done, skip_next, acc_wr, pair_wr, e, tk, b, f;
  logic        pready, pslverr, halt_mode, stop_mode, mem_req, mem_we, mem_wide;
  logic [7:0]  paddr = 8'h00, op_disp = 8'h00, acc_wdata, program_status_word, w;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'd75730;
  logic [19:0] op_imm = 20'h0, op_pc = 20'h0, pc_next, mem_addr, a;
  logic [15:0] accumulator_pair = 16'h0, register_pair = 16'h0, memory_pointer_pair = 16'h0040;
  logic [15:0] pair_wdata, stack_pointer, mem_wdata, mem_rdata;
  logic [3:0]  extra_segment_register = 4'h3, code_segment = 4'h5;
  logic [2:0]  op_bit = 3'h0;
  logic [1:0]  op_bank = 2'h0;
  csb_op_type  op_code = OP_NOP;
  csb_src_type op_src = SRC_ACC;
  int          fails = 0, samples_checked = 0, n, ec;
  csb_op_type  ops [12] = '{OP_BR_CARRY, OP_BR_NO_CARRY, OP_BR_ZERO, OP_BR_NO_ZERO, OP_HIGHER, OP_NOT_HIGHER,
    OP_SKIP_CARRY, OP_SKIP_NO_CARRY, OP_SKIP_ZERO, OP_SKIP_NO_ZERO, OP_HIGHER_SKIP, OP_NOT_HIGHER_SKIP};
  csb_op_type  bops [3] = '{OP_BIT_TRUE, OP_BIT_FALSE, OP_TEST_CLEAR};
  csb_src_type srcs [3] = '{SRC_ACC, SRC_PTR, SRC_SEG_PTR};
  always #25 mclk = ~mclk;
  csb_exec u_dut (.*);
  csb_mem_model u_mem (.mclk, .mem_req, .mem_we, .mem_wide, .mem_addr, .mem_wdata, .mem_rdata);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic cond(input int k, input logic c, input logic z);
    logic t [6] = '{c, !c, z, !z, !(c | z), c | z};
    return t[k];
  endfunction
  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n == 20) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic issue(input csb_op_type c, input csb_src_type s, input logic fl, input int cy, input int len,
                       input logic t);
    op_valid <= 1'b1;
    op_code <= c;
    op_src <= s;
    op_flash <= fl;
    op_pc <= 20'(rnd());
    op_disp <= 8'(rnd());
    @(posedge mclk);
    b = op_ready;
    op_valid <= 1'b0;
    for (n = 0; n < 12; n++) begin
      @(posedge mclk);
      if (done === 1'b1) break;
    end
    chk(b, 1'b1);
    chk(n, cy);
    if (len > 0) chk(pc_next, 20'(op_pc + 20'(len) + (t ? {{12{op_disp[7]}}, op_disp} : 20'h0)));
    if (n == 12) wrap_up();
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b1, 8'h04, 32'h0000_0200);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_0200);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, e}, 32'h1);
    register_pair <= 16'(rnd());
    issue(OP_PUSH_PAIR, SRC_ACC, 1'b0, 1, 1, 1'b0);
    chk({stack_pointer, u_mem.ram[20'hF01FF], u_mem.ram[20'hF01FE]}, {16'h01FE, register_pair});
    issue(OP_POP_PAIR, SRC_ACC, 1'b0, 1, 1, 1'b0);
    chk({stack_pointer, pair_wdata}, {16'h0200, register_pair});
    apb(1'b1, 8'h00, rnd());
    issue(OP_PUSH_STATUS, SRC_ACC, 1'b0, 1, 2, 1'b0);
    chk({stack_pointer, u_mem.ram[20'hF01FF], u_mem.ram[20'hF01FE]}, {16'h01FE, pwdata[7:0], 8'h00});
    w = pwdata[7:0];
    apb(1'b1, 8'h00, 32'h0);
    issue(OP_POP_STATUS, SRC_ACC, 1'b0, 3, 2, 1'b0);
    chk({stack_pointer, program_status_word}, {16'h0200, w});
    for (int k = 0; k < 24; k++) begin
      apb(1'b1, 8'h00, rnd());
      tk = cond(k % 6, pwdata[0], pwdata[6]);
      if (k % 12 < 6) issue(ops[k % 12], SRC_ACC, 1'b0, tk ? 4 : 2, k % 6 < 4 ? 2 : 3, tk);
      else issue(ops[k % 12], SRC_ACC, 1'b0, 1, 2, 1'b0);
      if (k % 12 >= 6) chk(skip_next, tk);
    end
    for (int k = 0; k < 18; k++) begin
      v = rnd();
      a = (k % 3 == 2) ? 20'h30040 : 20'hF0040;
      u_mem.ram[a] = v[7:0];
      accumulator_pair <= v[15:0];
      op_bit <= v[18:16];
      f = ((k / 3) % 2 == 1) && k % 3 != 0 && k < 12;
      w = (k % 3 == 0) ? v[15:8] : v[7:0];
      tk = (k / 6 == 1) ? !w[v[18:16]] : w[v[18:16]];
      ec = (k % 3 == 0) ? 3 : (k % 3 == 1) ? (f ? 6 : 3) : (f ? 7 : 4);
      issue(bops[k / 6], srcs[k % 3], f, tk ? ec + (f ? 1 : 2) : ec, (k % 3 == 2) ? 4 : 3, tk);
      if (k / 6 == 2 && tk) w[v[18:16]] = 1'b0;
      if (k % 3 != 0) chk(u_mem.ram[a], w);
      else if (k / 6 == 2 && tk) chk(acc_wdata, w);
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      apb(1'b1, 8'h00, {24'h0, v[15:8]});
      u_mem.ram[20'hF0080] = v[7:0];
      op_imm <= 20'hF0080;
      op_bit <= v[18:16];
      w = (k % 2) ? v[15:8] : v[7:0];
      tk = w[v[18:16]];
      issue(k < 2 ? OP_TEST_CLEAR : OP_BIT_TRUE, (k % 2) ? SRC_STATUS : SRC_SHORT_DIRECT, 1'b0,
            tk ? 5 : 3, 4, tk);
      if (k < 2 && tk) w[v[18:16]] = 1'b0;
      chk((k % 2) ? program_status_word : u_mem.ram[20'hF0080], w);
    end
    op_imm <= 20'(rnd());
    issue(OP_BR_LONG, SRC_ACC, 1'b0, 3, 0, 1'b0);
    chk(pc_next, 20'(op_pc + 20'h3 + {{4{op_imm[15]}}, op_imm[15:0]}));
    accumulator_pair <= 16'(rnd());
    issue(OP_BR_ACC, SRC_ACC, 1'b0, 3, 0, 1'b0);
    chk(pc_next, {code_segment, accumulator_pair});
    issue(OP_BR_SHORT, SRC_ACC, 1'b0, 3, 2, 1'b1);
    op_imm <= 20'(rnd());
    issue(OP_BR_ABS, SRC_ACC, 1'b0, 3, 0, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, {12'h000, op_imm});
    apb(1'b1, 8'h00, 32'h0000_0080);
    issue(OP_INT_DISABLE, SRC_ACC, 1'b0, 4, 3, 1'b0);
    chk(program_status_word, 8'h00);
    issue(OP_INT_ENABLE, SRC_ACC, 1'b0, 4, 3, 1'b0);
    op_bank <= 2'h2;
    issue(OP_BANK_SELECT, SRC_ACC, 1'b0, 1, 2, 1'b0);
    chk(program_status_word, 8'hA0);
    issue(OP_NOP, SRC_ACC, 1'b0, 1, 1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      issue(k ? OP_STOP : OP_HALT, SRC_ACC, 1'b0, 3, 2, 1'b0);
      chk({stop_mode, halt_mode, op_ready}, k ? 3'b100 : 3'b010);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, k ? 32'h9 : 32'h5);
      wake <= 1'b1;
      @(posedge mclk);
      wake <= 1'b0;
      @(posedge mclk);
      chk({stop_mode, halt_mode}, 2'b00);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
